// [core/sdrci_pkg.sv]
// sdrci_pkg: shared constants and types for the sdram command interface.
// assumes a single 100 MHz clock shared by controller and memory model.
package sdrci_pkg;
  localparam int SDRCI_ADDR_W = 13;
  localparam int SDRCI_COL_W = 9;
  localparam int SDRCI_DATA_W = 32;
  localparam int SDRCI_BYTES = 4;
  localparam int SDRCI_BANKS = 4;
  localparam int SDRCI_AP_BIT = 10;
  localparam int SDRCI_MASK_LAT = 2;
  localparam int SDRCI_MEM_WORDS = 64;
  localparam int SDRCI_MEM_AW = 6;
  // mode register fields
  localparam int SDRCI_MR_BL_LSB = 0;
  localparam int SDRCI_MR_BT_BIT = 3;
  localparam int SDRCI_MR_CL_LSB = 4;
  localparam logic [2:0] SDRCI_BL_FULL = 3'h7;
  localparam logic [2:0] SDRCI_CL_RESET = 3'h2;
  localparam logic [2:0] SDRCI_BL_RESET = 3'h2;
  // controller timing, in ns, and derived counts at 10 ns
  localparam int SDRCI_CLK_NS = 10;
  localparam int SDRCI_ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int SDRCI_TRC_NS = 70;
  localparam int SDRCI_BANK_TO_BANK_DELAY_NS = 20;
  localparam int SDRCI_ROW_ACTIVE_TIME_NS = 50;
  localparam int SDRCI_TRP_NS = 20;
  localparam int SDRCI_ROW_TO_COLUMN_DELAY_CYC = (SDRCI_ROW_TO_COLUMN_DELAY_NS + SDRCI_CLK_NS - 1) / SDRCI_CLK_NS;
  localparam int SDRCI_TRC_CYC = (SDRCI_TRC_NS + SDRCI_CLK_NS - 1) / SDRCI_CLK_NS;
  localparam int SDRCI_BANK_TO_BANK_DELAY_CYC = (SDRCI_BANK_TO_BANK_DELAY_NS + SDRCI_CLK_NS - 1) / SDRCI_CLK_NS;
  localparam int SDRCI_ROW_ACTIVE_TIME_CYC = (SDRCI_ROW_ACTIVE_TIME_NS + SDRCI_CLK_NS - 1) / SDRCI_CLK_NS;
  localparam int SDRCI_TRP_CYC = (SDRCI_TRP_NS + SDRCI_CLK_NS - 1) / SDRCI_CLK_NS;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SDRCI_C_ACT = 4'h3;
  localparam logic [3:0] SDRCI_C_PRE = 4'h2;
  localparam logic [3:0] SDRCI_C_WR = 4'h4;
  localparam logic [3:0] SDRCI_C_RD = 4'h5;
  localparam logic [3:0] SDRCI_C_MRS = 4'h0;
  localparam logic [3:0] SDRCI_C_NOP = 4'h7;
  localparam logic [3:0] SDRCI_C_STOP = 4'h6;
  localparam logic [3:0] SDRCI_C_REF = 4'h1;
  localparam logic [3:0] SDRCI_C_DESEL = 4'hF;
  typedef enum logic [2:0] {
    SDRCI_OP_NONE, SDRCI_OP_ACT, SDRCI_OP_PRE, SDRCI_OP_RD, SDRCI_OP_WR, SDRCI_OP_MRS,
    SDRCI_OP_REF, SDRCI_OP_STOP
  } sdrci_op_type;
endpackage

// [core/sdrci_if.sv]
// sdrci_if: the sdram pin bundle between controller and memory.
// assumes both ends share clk; data_bus wire level resolved here from enables.
`timescale 1ns/1ps
interface sdrci_if;
  import sdrci_pkg::*;
  logic clk_gate;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank_sel;
  logic [SDRCI_ADDR_W-1:0] addr;
  logic [SDRCI_BYTES-1:0] byte_mask;
  logic [SDRCI_DATA_W-1:0] dq_ctl_out;
  logic dq_ctl_oe;
  logic [SDRCI_DATA_W-1:0] dq_mem_out;
  logic [SDRCI_BYTES-1:0] dq_mem_oe;
  logic [SDRCI_DATA_W-1:0] data_bus;
  always_comb begin
    for (int i = 0; i < SDRCI_BYTES; i++) begin
      if (dq_mem_oe[i]) begin
        data_bus[i*8 +: 8] = dq_mem_out[i*8 +: 8];
      end else if (dq_ctl_oe) begin
        data_bus[i*8 +: 8] = dq_ctl_out[i*8 +: 8];
      end else begin
        data_bus[i*8 +: 8] = 8'h00;
      end
    end
  end
  modport ctl (output clk_gate, cs_n, ras_n, cas_n, we_n, bank_sel, addr, byte_mask,
    dq_ctl_out, dq_ctl_oe, input data_bus);
  modport mem (input clk_gate, cs_n, ras_n, cas_n, we_n, bank_sel, addr, byte_mask,
    dq_ctl_out, dq_ctl_oe, output dq_mem_out, dq_mem_oe);
endinterface

// [core/sdrci_ctl.sv]
// sdrci_ctl: controller end; turns one user request into pin commands.
// assumes the user waits for req_ready; user sets clk_gate level via req_clk_gate, registered one clock.
`timescale 1ns/1ps
module sdrci_ctl
  import sdrci_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire sdrci_op_type req_op,
  input wire logic [1:0] req_bank,
  input wire logic [SDRCI_ADDR_W-1:0] req_addr,
  input wire logic [SDRCI_BYTES-1:0] req_mask,
  input wire logic [SDRCI_DATA_W-1:0] req_wdata,
  input wire logic req_clk_gate,
  // read data sample
  output logic [SDRCI_DATA_W-1:0] rd_sample,
  // pins
  sdrci_if.ctl pins
);
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [SDRCI_ADDR_W-1:0] addr;
  logic [SDRCI_BYTES-1:0] mask;
  logic [SDRCI_DATA_W-1:0] wdata;
  logic drive;
  logic gate;
  logic [3:0] bank_wait [SDRCI_BANKS];
  logic [3:0] rrd_wait;
  logic [3:0] next_cmd;
  wire is_act = req_op == SDRCI_OP_ACT;
  wire is_col = req_op == SDRCI_OP_RD || req_op == SDRCI_OP_WR;
  // a single wait counter per bank holds off the bank for row_active_time after an activate and for trp after a precharge
  wire bank_ok = bank_wait[req_bank] == 4'h0;
  wire rrd_ok = !is_act || rrd_wait == 4'h0;
  assign req_ready = bank_ok && rrd_ok;
  wire take = req_valid && req_ready;
  always_comb begin
    case (req_op)
      SDRCI_OP_ACT: next_cmd = SDRCI_C_ACT;
      SDRCI_OP_PRE: next_cmd = SDRCI_C_PRE;
      SDRCI_OP_RD: next_cmd = SDRCI_C_RD;
      SDRCI_OP_WR: next_cmd = SDRCI_C_WR;
      SDRCI_OP_MRS: next_cmd = SDRCI_C_MRS;
      SDRCI_OP_REF: next_cmd = SDRCI_C_REF;
      SDRCI_OP_STOP: next_cmd = SDRCI_C_STOP;
      default: next_cmd = SDRCI_C_NOP;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= SDRCI_C_DESEL;
      bank <= 2'h0;
      addr <= '0;
      mask <= '1;
      wdata <= '0;
      drive <= 1'b0;
      gate <= 1'b0;
      rrd_wait <= 4'h0;
      rd_sample <= '0;
      for (int b = 0; b < SDRCI_BANKS; b++) begin
        bank_wait[b] <= 4'h0;
      end
    end else begin
      gate <= req_clk_gate;
      cmd <= take ? next_cmd : SDRCI_C_NOP;
      bank <= req_bank;
      addr <= req_addr;
      mask <= req_mask;
      wdata <= req_wdata;
      drive <= take && req_op == SDRCI_OP_WR;
      rd_sample <= pins.data_bus;
      if (rrd_wait != 4'h0) begin
        rrd_wait <= rrd_wait - 4'h1;
      end else if (take && is_act) begin
        rrd_wait <= 4'(SDRCI_BANK_TO_BANK_DELAY_CYC - 1);
      end
      for (int b = 0; b < SDRCI_BANKS; b++) begin
        if (bank_wait[b] != 4'h0) begin
          bank_wait[b] <= bank_wait[b] - 4'h1;
        end else if (take && req_bank == 2'(b)) begin
          if (is_act) begin
            bank_wait[b] <= 4'(SDRCI_ROW_ACTIVE_TIME_CYC - 1);
          end else if (req_op == SDRCI_OP_PRE) begin
            bank_wait[b] <= 4'(SDRCI_TRP_CYC - 1);
          end else if (is_col) begin
            bank_wait[b] <= 4'h0;
          end
        end
      end
    end
  end
  assign pins.clk_gate = gate;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd;
  assign pins.bank_sel = bank;
  assign pins.addr = addr;
  assign pins.byte_mask = mask;
  assign pins.dq_ctl_out = wdata;
  assign pins.dq_ctl_oe = drive;
endmodule

// [core/sdrci_mem.sv]
// sdrci_mem: memory end; decodes commands, keeps bank state, bursts reads.
// assumes the controller keeps its own timing; memory is a small model array.
`timescale 1ns/1ps
module sdrci_mem
  import sdrci_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // status
  output logic [SDRCI_BANKS-1:0] bank_open,
  output logic powered_down,
  output logic self_refresh,
  output logic bursting,
  // pins
  sdrci_if.mem pins
);
  typedef enum logic [1:0] {SDRCI_RUN, SDRCI_SUSPEND, SDRCI_PDOWN, SDRCI_SREF} sdrci_mode_type;
  sdrci_mode_type mode;
  logic prev_clk_gate_level;
  logic [SDRCI_DATA_W-1:0] store [SDRCI_MEM_WORDS];
  logic [SDRCI_ADDR_W-1:0] open_row [SDRCI_BANKS];
  logic [12:0] mode_reg;
  logic [1:0] burst_bank;
  logic [SDRCI_COL_W-1:0] burst_col;
  logic [SDRCI_COL_W-1:0] burst_start;
  logic [9:0] burst_left;
  logic burst_ap;
  logic [3:0] lat_pipe;
  logic [SDRCI_BYTES-1:0] mask_d1;
  logic [SDRCI_BYTES-1:0] mask_d2;
  logic [SDRCI_DATA_W-1:0] dout;
  logic dout_en;
  function automatic logic [SDRCI_MEM_AW-1:0] word_of(input logic [1:0] b,
      input logic [SDRCI_COL_W-1:0] c);
    word_of = {b, c[SDRCI_MEM_AW-3:0]};
  endfunction
  // chip select high masks the whole command
  wire [3:0] cmd = pins.cs_n ? SDRCI_C_DESEL : {1'b0, pins.ras_n, pins.cas_n, pins.we_n};
  wire gate_now = pins.clk_gate;
  wire live = prev_clk_gate_level;
  wire idle_cmd = cmd == SDRCI_C_DESEL || cmd == SDRCI_C_NOP;
  wire all_idle = bank_open == '0;
  wire run = mode == SDRCI_RUN && live;
  wire c_act = run && cmd == SDRCI_C_ACT;
  wire c_pre = run && cmd == SDRCI_C_PRE;
  wire c_rd = run && cmd == SDRCI_C_RD;
  wire c_wr = run && cmd == SDRCI_C_WR;
  wire c_mrs = run && cmd == SDRCI_C_MRS && all_idle;
  wire c_stop = run && cmd == SDRCI_C_STOP;
  wire pre_all = pins.addr[SDRCI_AP_BIT];
  wire [2:0] bl_code = mode_reg[SDRCI_MR_BL_LSB +: 3];
  wire [2:0] cl = mode_reg[SDRCI_MR_CL_LSB +: 3];
  wire full_page = bl_code == SDRCI_BL_FULL;
  wire [9:0] bl_len = full_page ? 10'h3FF : 10'(1 << bl_code);
  wire interleave = mode_reg[SDRCI_MR_BT_BIT];
  wire [SDRCI_COL_W-1:0] step = burst_col - burst_start + 9'h001;
  wire [SDRCI_COL_W-1:0] wrap_mask = 9'(bl_len - 10'h1);
  wire [SDRCI_COL_W-1:0] seq_col = (burst_start & ~wrap_mask) | ((burst_start + step) & wrap_mask);
  wire [SDRCI_COL_W-1:0] ilv_col = burst_start ^ (step & wrap_mask);
  wire [SDRCI_COL_W-1:0] next_col = full_page ? burst_col + 9'h001
                                              : (interleave ? ilv_col : seq_col);
  wire cut = c_stop || c_wr || (c_pre && (pre_all || pins.bank_sel == burst_bank));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_clk_gate_level <= 1'b0;
      mode <= SDRCI_RUN;
    end else begin
      prev_clk_gate_level <= gate_now;
      case (mode)
        SDRCI_RUN: begin
          if (live && !gate_now) begin
            if (cmd == SDRCI_C_REF && all_idle) begin
              mode <= SDRCI_SREF;
            end else if (bursting || !all_idle && !idle_cmd) begin
              mode <= SDRCI_SUSPEND;
            end else if (idle_cmd) begin
              mode <= SDRCI_PDOWN;
            end else begin
              mode <= SDRCI_SUSPEND;
            end
          end
        end
        SDRCI_SUSPEND: if (gate_now) mode <= SDRCI_RUN;
        SDRCI_PDOWN, SDRCI_SREF: if (gate_now && idle_cmd) mode <= SDRCI_RUN;
        default: mode <= SDRCI_RUN;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank_open <= '0;
      mode_reg <= 13'({SDRCI_CL_RESET, 1'b0, SDRCI_BL_RESET});
      bursting <= 1'b0;
      burst_bank <= 2'h0;
      burst_col <= '0;
      burst_start <= '0;
      burst_left <= '0;
      burst_ap <= 1'b0;
      lat_pipe <= '0;
      mask_d1 <= '1;
      mask_d2 <= '1;
      dout <= '0;
      dout_en <= 1'b0;
      for (int b = 0; b < SDRCI_BANKS; b++) begin
        open_row[b] <= '0;
      end
    end else if (mode == SDRCI_RUN && gate_now) begin
      mask_d1 <= pins.byte_mask;
      mask_d2 <= mask_d1;
      lat_pipe <= {lat_pipe[2:0], c_rd};
      if (c_mrs) begin
        mode_reg <= pins.addr;
      end
      if (c_act && !bank_open[pins.bank_sel]) begin
        bank_open[pins.bank_sel] <= 1'b1;
        open_row[pins.bank_sel] <= pins.addr;
      end
      if (c_pre) begin
        if (pre_all) begin
          bank_open <= '0;
        end else begin
          bank_open[pins.bank_sel] <= 1'b0;
        end
      end
      if (c_wr && bank_open[pins.bank_sel]) begin
        for (int i = 0; i < SDRCI_BYTES; i++) begin
          if (!pins.byte_mask[i]) begin
            store[word_of(pins.bank_sel, pins.addr[SDRCI_COL_W-1:0])][i*8 +: 8] <=
              pins.dq_ctl_out[i*8 +: 8];
          end
        end
      end
      if (c_rd && bank_open[pins.bank_sel]) begin
        // new read replaces any running burst on the next clock
        bursting <= 1'b1;
        burst_bank <= pins.bank_sel;
        burst_col <= pins.addr[SDRCI_COL_W-1:0];
        burst_start <= pins.addr[SDRCI_COL_W-1:0];
        burst_left <= bl_len;
        burst_ap <= pins.addr[SDRCI_AP_BIT];
      end else if (cut) begin
        bursting <= 1'b0;
      // latency 3 holds the first column one extra clock before it is driven
      end else if (bursting && (cl != 3'h3 || !lat_pipe[0]) && burst_left != 10'h0) begin
        burst_col <= next_col;
        if (!full_page) begin
          burst_left <= burst_left - 10'h1;
        end
        if (burst_left == 10'h1 && !full_page) begin
          bursting <= 1'b0;
          if (burst_ap) bank_open[burst_bank] <= 1'b0;
        end
      end
      dout_en <= bursting && !cut && !(cl == 3'h3 && lat_pipe[0]);
      dout <= store[word_of(burst_bank, burst_col)];
    end
  end
  assign pins.dq_mem_out = dout;
  assign pins.dq_mem_oe = dout_en ? ~mask_d2 : '0;
  assign powered_down = mode == SDRCI_PDOWN;
  assign self_refresh = mode == SDRCI_SREF;
endmodule

// [verif/sdrci_monitor.sv]
// sdrci_monitor: pin-level checks on the link between controller and memory.
// assumes the shared clk and rstn of both ends; mode register left at its reset value.
`timescale 1ns/1ps
module sdrci_monitor
  import sdrci_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // command pins
  input wire logic clk_gate,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_sel,
  input wire logic [SDRCI_ADDR_W-1:0] addr,
  input wire logic [SDRCI_BYTES-1:0] byte_mask,
  // memory drive
  input wire logic [SDRCI_BYTES-1:0] dq_mem_oe
);
  logic gate_prev;
  logic [3:0] age [SDRCI_BANKS];
  wire logic [3:0] cmd;
  wire logic act;
  wire logic rd;
  wire logic rw;
  wire logic pre;
  wire logic quiet;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // a command only counts when the gate was high one clock earlier
  assign act = gate_prev && cmd == SDRCI_C_ACT;
  assign rd = gate_prev && clk_gate && cmd == SDRCI_C_RD;
  assign rw = gate_prev && (cmd == SDRCI_C_RD || cmd == SDRCI_C_WR);
  assign pre = gate_prev && cmd == SDRCI_C_PRE;
  assign quiet = clk_gate && byte_mask == 4'h0 && (cs_n || cmd == SDRCI_C_NOP);
  // cycles since each bank's activate, saturating well above every spacing used
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_prev <= 1'b0;
      for (int b = 0; b < SDRCI_BANKS; b++) age[b] <= 4'hF;
    end else begin
      gate_prev <= clk_gate;
      for (int b = 0; b < SDRCI_BANKS; b++) begin
        if (act && bank_sel == b[1:0]) age[b] <= 4'h1;
        else if (age[b] != 4'hF) age[b] <= age[b] + 4'h1;
      end
    end
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  rcd_gap_a: assert property (rw |-> age[bank_sel] >= SDRCI_ROW_TO_COLUMN_DELAY_CYC)
    else $error("access too soon after activate");
  rc_gap_a: assert property (act |-> age[bank_sel] >= SDRCI_TRC_CYC)
    else $error("activate too soon after activate of same bank");
  rrd_gap_a: assert property (act |=> !act)
    else $error("activates to two banks on consecutive clocks");
  ras_min_a: assert property (pre && !addr[SDRCI_AP_BIT] |-> age[bank_sel] >= SDRCI_ROW_ACTIVE_TIME_CYC)
    else $error("bank closed before minimum active time");
  read_latency_a: assert property ((rd && byte_mask == 4'h0) ##1 clk_gate [*2] |-> dq_mem_oe == 4'hF)
    else $error("first read word not driven two clocks after read");
  burst_end_a: assert property ((rd && byte_mask == 4'h0) ##1 quiet [*5] |->
    dq_mem_oe == 4'hF ##1 dq_mem_oe == 4'h0)
    else $error("data bus not released after four word burst");
  mask_delay_a: assert property (clk_gate && $past(clk_gate) && $past(clk_gate, 2) |->
    (dq_mem_oe & $past(byte_mask, 2)) == 4'h0)
    else $error("byte driven although masked two clocks earlier");
  gate_freeze_a: assert property (!clk_gate |=> $stable(dq_mem_oe))
    else $error("memory outputs moved while clock suspended");
  wake_nop_a: assert property ($rose(clk_gate) |-> cs_n || cmd == SDRCI_C_NOP)
    else $error("gate raised with a live command");
endmodule

// [verif/sdram_command_interface_test.sv]
// sdram_command_interface_test: controller and memory joined by the pin bundle.
// assumes mode register stays at reset (latency 2, burst 4); no other stimulus source.
`timescale 1ns/1ps
module sdram_command_interface_test;
  import sdrci_pkg::*;
  typedef struct {
    sdrci_op_type op;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [3:0] mask;
    logic [31:0] wdata;
    logic [3:0] open;
    logic [31:0] rdata;
  } sdrci_row_type;
  logic clk;
  logic rstn;
  logic req_valid;
  logic req_ready;
  sdrci_op_type req_op;
  logic [1:0] req_bank;
  logic [SDRCI_ADDR_W-1:0] req_addr;
  logic [SDRCI_BYTES-1:0] req_mask;
  logic [SDRCI_DATA_W-1:0] req_wdata;
  logic req_clk_gate;
  logic [SDRCI_DATA_W-1:0] rd_sample;
  logic [SDRCI_BANKS-1:0] bank_open;
  logic powered_down;
  logic self_refresh;
  logic bursting;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int rd_q [$];
  int dqc_q [$];
  logic [31:0] dq_q [$];
  logic [31:0] w;
  sdrci_row_type rows [11] = '{
    '{SDRCI_OP_ACT, 2'h0, 13'h0005, 4'h0, 32'h0, 4'h1, 32'h0},
    '{SDRCI_OP_ACT, 2'h1, 13'h0009, 4'h0, 32'h0, 4'h3, 32'h0},
    '{SDRCI_OP_WR, 2'h0, 13'h0000, 4'h0, 32'hAAAAAAAA, 4'h3, 32'h0},
    '{SDRCI_OP_WR, 2'h0, 13'h0000, 4'hC, 32'h55555555, 4'h3, 32'h0},
    '{SDRCI_OP_RD, 2'h0, 13'h0000, 4'h0, 32'h0, 4'h3, 32'hAAAA5555},
    '{SDRCI_OP_RD, 2'h0, 13'h0000, 4'h1, 32'h0, 4'h3, 32'hAAAA5500},
    '{SDRCI_OP_WR, 2'h1, 13'h0001, 4'h0, 32'h12345678, 4'h3, 32'h0},
    '{SDRCI_OP_RD, 2'h1, 13'h0001, 4'h0, 32'h0, 4'h3, 32'h12345678},
    '{SDRCI_OP_PRE, 2'h0, 13'h0000, 4'h0, 32'h0, 4'h2, 32'h0},
    '{SDRCI_OP_PRE, 2'h3, 13'h0400, 4'h0, 32'h0, 4'h0, 32'h0},
    '{SDRCI_OP_REF, 2'h0, 13'h0000, 4'h0, 32'h0, 4'h0, 32'h0}};

  sdrci_if sdrci_if_i ();
  sdrci_ctl sdrci_ctl_i (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask),
    .req_wdata(req_wdata), .req_clk_gate(req_clk_gate), .rd_sample(rd_sample),
    .pins(sdrci_if_i.ctl));
  sdrci_mem sdrci_mem_i (.clk(clk), .rstn(rstn), .bank_open(bank_open),
    .powered_down(powered_down), .self_refresh(self_refresh), .bursting(bursting),
    .pins(sdrci_if_i.mem));
  sdrci_monitor sdrci_monitor_i (.clk(clk), .rstn(rstn), .clk_gate(sdrci_if_i.clk_gate),
    .cs_n(sdrci_if_i.cs_n), .ras_n(sdrci_if_i.ras_n), .cas_n(sdrci_if_i.cas_n),
    .we_n(sdrci_if_i.we_n), .bank_sel(sdrci_if_i.bank_sel), .addr(sdrci_if_i.addr),
    .byte_mask(sdrci_if_i.byte_mask), .dq_mem_oe(sdrci_if_i.dq_mem_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // log read commands and driven words by clock count, for latency and interrupt checks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if ({sdrci_if_i.cs_n, sdrci_if_i.ras_n, sdrci_if_i.cas_n, sdrci_if_i.we_n} === SDRCI_C_RD)
      rd_q.push_back(cyc);
    if (|sdrci_if_i.dq_mem_oe) begin
      dq_q.push_back(sdrci_if_i.data_bus);
      dqc_q.push_back(cyc);
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input sdrci_row_type r);
    int n;
    @(negedge clk);
    req_op = r.op;
    req_bank = r.bank;
    req_addr = r.addr;
    req_mask = r.mask;
    req_wdata = r.wdata;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) check("req_ready", 32'h1, {31'h0, req_ready});
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // word driven exactly one read latency after the k-th logged read command
  task automatic word_at(input int k, output logic [31:0] v);
    v = 'x;
    if (rd_q.size() > k) begin
      foreach (dqc_q[i]) if (dqc_q[i] == rd_q[k] + int'(SDRCI_CL_RESET)) v = dq_q[i];
    end
  endtask
  task automatic run_row(input sdrci_row_type r);
    rd_q.delete();
    dq_q.delete();
    dqc_q.delete();
    send(r);
    repeat (10) @(negedge clk);
    check("bank_open", {28'h0, r.open}, {28'h0, bank_open});
    if (r.op == SDRCI_OP_RD) begin
      word_at(0, w);
      check("read word", r.rdata, w);
    end
  endtask

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_op = SDRCI_OP_NONE;
    req_bank = 2'h0;
    req_addr = 13'h0000;
    req_mask = 4'h0;
    req_wdata = 32'h0;
    req_clk_gate = 1'b1;
    repeat (10) @(negedge clk);
    check("reset bank_open", 32'h0, {28'h0, bank_open});
    check("reset cs_n", 32'h1, {31'h0, sdrci_if_i.cs_n});
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    $display("reset test done");
    foreach (rows[i]) run_row(rows[i]);
    $display("table test done");
    // second read cuts the first burst short; words from it follow its own latency
    run_row('{SDRCI_OP_ACT, 2'h2, 13'h0003, 4'h0, 32'h0, 4'h4, 32'h0});
    run_row('{SDRCI_OP_WR, 2'h2, 13'h0000, 4'h0, 32'h0F0F0F0F, 4'h4, 32'h0});
    run_row('{SDRCI_OP_WR, 2'h2, 13'h0002, 4'h0, 32'hF0F0F0F0, 4'h4, 32'h0});
    rd_q.delete();
    dq_q.delete();
    dqc_q.delete();
    send('{SDRCI_OP_RD, 2'h2, 13'h0002, 4'h0, 32'h0, 4'h4, 32'h0});
    send('{SDRCI_OP_RD, 2'h2, 13'h0000, 4'h0, 32'h0, 4'h4, 32'h0});
    repeat (10) @(negedge clk);
    word_at(0, w);
    check("first burst word", 32'hF0F0F0F0, w);
    word_at(1, w);
    check("interrupting word", 32'h0F0F0F0F, w);
    $display("interrupt test done");
    // gate dropped under a nop with a bank open but no burst: active power down
    req_clk_gate = 1'b0;
    repeat (4) @(negedge clk);
    check("powered_down", 32'h1, {31'h0, powered_down});
    req_clk_gate = 1'b1;
    repeat (4) @(negedge clk);
    check("powered_down", 32'h0, {31'h0, powered_down});
    run_row('{SDRCI_OP_PRE, 2'h0, 13'h0400, 4'h0, 32'h0, 4'h0, 32'h0});
    req_clk_gate = 1'b0;
    repeat (4) @(negedge clk);
    check("powered_down", 32'h1, {31'h0, powered_down});
    req_clk_gate = 1'b1;
    repeat (4) @(negedge clk);
    check("powered_down", 32'h0, {31'h0, powered_down});
    $display("power down test done");
    end_of_test();
  end
  // whole run is a few hundred clocks; this leaves ample margin
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
endmodule
